/* hw/tcr_defs.svh */
`ifndef TCR_DEFS_SVH
`define TCR_DEFS_SVH

// register byte addresses on the internal data bus
`define TCR_ADDR_CTRL 8'h15
`define TCR_ADDR_CNT_LO 8'h32
`define TCR_ADDR_CNT_HI 8'h33
`define TCR_ADDR_CMP_A 8'h36
`define TCR_ADDR_CMP_B 8'h37

// control register field positions
`define TCR_BIT_WIDE 7
`define TCR_BIT_CAPEN 6
`define TCR_BIT_FILT 5
`define TCR_BIT_EDGE 4
`define TCR_BIT_ACSEL 3
`define TCR_BIT_CTC 0

// writable bits of the control register, reserved 2:1 masked out
`define TCR_CTRL_WMASK 8'hF9

// reset values
`define TCR_CTRL_RST 8'h00
`define TCR_BYTE_RST 8'h00
`define TCR_WORD_RST 16'h0000
`define TCR_READ_IDLE 8'h00

// noise filter sample count
`define TCR_FILT_LEN 4

`endif

/* hw/tcr_pkg.sv */
package tcr_pkg;

	// one access of the processor on the 8-bit data bus
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} tcr_bus_req_t;

	// decoded control register fields
	typedef struct packed {
		logic wide;
		logic capen;
		logic filt;
		logic edge_rise;
		logic acsel;
		logic ctc;
	} tcr_ctrl_t;

	// sticky event flags, also used for the clear strobes
	typedef struct packed {
		logic cap;
		logic cmp_a;
		logic cmp_b;
	} tcr_flags_t;

endpackage

/* hw/tcr_timer.sv */
`timescale 1ns/1ps
`include "tcr_defs.svh"

module tcr_timer
	import tcr_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire tcr_bus_req_t bus_i,
	output logic [7:0] rdata_o,
	input wire logic timer_tick_i,
	input wire logic capture_input_pin_i,
	input wire logic comparator_out_i,
	input wire logic capture_irq_enable_i,
	input wire tcr_flags_t flag_clear_i,
	output tcr_flags_t flags_o,
	output logic capture_irq_o,
	output logic [15:0] counter_o
);

	// pack the control fields back into a byte, reserved bits zero
	function automatic logic [7:0] ctrl_to_byte(input tcr_ctrl_t c);
		logic [7:0] b;
		b = 8'h00;
		b[`TCR_BIT_WIDE] = c.wide;
		b[`TCR_BIT_CAPEN] = c.capen;
		b[`TCR_BIT_FILT] = c.filt;
		b[`TCR_BIT_EDGE] = c.edge_rise;
		b[`TCR_BIT_ACSEL] = c.acsel;
		b[`TCR_BIT_CTC] = c.ctc;
		return b;
	endfunction

	// unpack a written byte into control fields
	function automatic tcr_ctrl_t byte_to_ctrl(input logic [7:0] b);
		tcr_ctrl_t c;
		c.wide = b[`TCR_BIT_WIDE];
		c.capen = b[`TCR_BIT_CAPEN];
		c.filt = b[`TCR_BIT_FILT];
		c.edge_rise = b[`TCR_BIT_EDGE];
		c.acsel = b[`TCR_BIT_ACSEL];
		c.ctc = b[`TCR_BIT_CTC];
		return c;
	endfunction

	// synchroniser flops for the two asynchronous trigger sources
	logic pin_s1_q; // first stage, read only by the second
	logic pin_s2_q; // pin, safe to use
	logic acmp_s1_q; // first stage, read only by the second
	logic acmp_s2_q; // comparator, safe to use

	// front end state
	logic [`TCR_FILT_LEN-1:0] hist_q; // last four samples
	logic [`TCR_FILT_LEN-1:0] hist_d;
	logic filt_q; // filtered level
	logic filt_d;
	logic prev_q; // level seen one cycle earlier
	logic prev_d;

	// register file and counter state
	tcr_ctrl_t ctrl_q; // control register fields
	tcr_ctrl_t ctrl_d;
	logic [15:0] cnt_q; // counter, high byte idle in 8-bit mode
	logic [15:0] cnt_d;
	logic [7:0] cmp_a_q; // compare A, capture low byte
	logic [7:0] cmp_a_d;
	logic [7:0] cmp_b_q; // compare B, capture high byte
	logic [7:0] cmp_b_d;
	logic [7:0] latch_q; // shared high-byte latch
	logic [7:0] latch_d;
	logic block_q; // match blocked until next tick
	logic block_d;
	tcr_flags_t flags_q; // sticky event flags
	tcr_flags_t flags_d;
	logic [7:0] rdata_q; // read data, valid the cycle after rd
	logic [7:0] rdata_d;
	logic irq_q; // capture interrupt request
	logic irq_d;

	// combinational helpers
	logic src_lvl; // selected raw trigger level
	logic fe_lvl; // level after optional filter
	logic edge_hit; // triggering edge in capture mode
	logic match_a; // compare A or combined compare equal
	logic match_b; // compare B equal, 8-bit mode only
	logic acc_ctrl; // address decode strobes
	logic acc_cnt_lo;
	logic acc_cnt_hi;
	logic acc_cmp_a;
	logic acc_cmp_b;

	// two-flop synchronisers, only the second stage reads the first stage
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
			acmp_s1_q <= 1'b0;
			acmp_s2_q <= 1'b0;
		end else begin
			pin_s1_q <= capture_input_pin_i;
			pin_s2_q <= pin_s1_q;
			acmp_s1_q <= comparator_out_i;
			acmp_s2_q <= acmp_s1_q;
		end
	end

	// capture front end: source select, filter, edge detect
	always_comb begin
		src_lvl = ctrl_q.acsel ? acmp_s2_q : pin_s2_q;
		hist_d = {hist_q[`TCR_FILT_LEN-2:0], src_lvl};
		filt_d = filt_q;
		// four equal samples flip
		// the sample taken now is the fourth, so the filter adds four cycles, not five
		if (&hist_d) begin
			filt_d = 1'b1;
		end else if (~|hist_d) begin
			filt_d = 1'b0;
		end
		// filter bypassed when off, so the added delay only applies when on
		fe_lvl = ctrl_q.filt ? filt_q : src_lvl;
		prev_d = fe_lvl;
		if (ctrl_q.edge_rise) begin
			edge_hit = fe_lvl & ~prev_q;
		end else begin
			edge_hit = ~fe_lvl & prev_q;
		end
		edge_hit = edge_hit & ctrl_q.capen;
	end

	// front end registers
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hist_q <= '0;
			filt_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			hist_q <= hist_d;
			filt_q <= filt_d;
			prev_q <= prev_d;
		end
	end

	// address decode, one strobe per register
	always_comb begin
		acc_ctrl = 1'b0;
		acc_cnt_lo = 1'b0;
		acc_cnt_hi = 1'b0;
		acc_cmp_a = 1'b0;
		acc_cmp_b = 1'b0;
		if (bus_i.addr == `TCR_ADDR_CTRL) begin
			acc_ctrl = 1'b1;
		end else if (bus_i.addr == `TCR_ADDR_CNT_LO) begin
			acc_cnt_lo = 1'b1;
		end else if (bus_i.addr == `TCR_ADDR_CNT_HI) begin
			acc_cnt_hi = 1'b1;
		end else if (bus_i.addr == `TCR_ADDR_CMP_A) begin
			acc_cmp_a = 1'b1;
		end else if (bus_i.addr == `TCR_ADDR_CMP_B) begin
			acc_cmp_b = 1'b1;
		end
	end

	// counter, compare, latch, flags and bus read path
	always_comb begin
		ctrl_d = ctrl_q;
		cnt_d = cnt_q;
		cmp_a_d = cmp_a_q;
		cmp_b_d = cmp_b_q;
		latch_d = latch_q;
		block_d = block_q;
		rdata_d = rdata_q;
		// compare B forms the high byte
		if (ctrl_q.wide) begin
			match_a = (cnt_q == {cmp_b_q, cmp_a_q});
		end else begin
			match_a = (cnt_q[7:0] == cmp_a_q);
		end
		match_b = ~ctrl_q.wide & (cnt_q[7:0] == cmp_b_q);
		// software clears first, so a same-cycle set below wins
		flags_d = flags_q & ~flag_clear_i;

		// timer tick: count and raise compare flags
		if (timer_tick_i) begin
			// flag on tick, wide only A
			if (!block_q && !ctrl_q.capen) begin
				flags_d.cmp_a = flags_d.cmp_a | match_a;
				flags_d.cmp_b = flags_d.cmp_b | match_b;
			end
			// block lasts exactly one tick
			block_d = 1'b0;
			if (ctrl_q.ctc && match_a) begin
				cnt_d = `TCR_WORD_RST;
			end else if (ctrl_q.wide) begin
				cnt_d = cnt_q + 16'h0001;
			end else begin
				// 8-bit mode wraps the low byte, high byte untouched
				cnt_d = {cnt_q[15:8], cnt_q[7:0] + 8'h01};
			end
		end

		// processor counter writes override counting in the same cycle, except a high-byte write in wide mode
		if (bus_i.wr) begin
			if (acc_ctrl) begin
				ctrl_d = byte_to_ctrl(bus_i.wdata & `TCR_CTRL_WMASK);
			end else if (acc_cnt_lo) begin
				block_d = 1'b1;
				if (ctrl_q.wide) begin
					cnt_d = {latch_q, bus_i.wdata};
				end else begin
					cnt_d = {cnt_q[15:8], bus_i.wdata};
				end
			end else if (acc_cnt_hi) begin
				// high byte goes to the shared latch
				latch_d = bus_i.wdata;
				block_d = 1'b1;
				if (!ctrl_q.wide) begin
					cnt_d = {bus_i.wdata, cnt_q[7:0]};
				end
			end else if (acc_cmp_a) begin
				cmp_a_d = bus_i.wdata;
				// latched high byte lands in compare B
				if (ctrl_q.wide) begin
					cmp_b_d = latch_q;
				end
			end else if (acc_cmp_b) begin
				// wide mode: high byte waits in the latch
				if (ctrl_q.wide) begin
					latch_d = bus_i.wdata;
				end else begin
					cmp_b_d = bus_i.wdata;
				end
			end
		end

		// processor reads, data appears one cycle later
		if (bus_i.rd) begin
			if (acc_ctrl) begin
				rdata_d = ctrl_to_byte(ctrl_q);
			end else if (acc_cnt_lo) begin
				rdata_d = cnt_q[7:0];
				if (ctrl_q.wide) begin
					latch_d = cnt_q[15:8];
				end
			end else if (acc_cnt_hi) begin
				rdata_d = ctrl_q.wide ? latch_q : cnt_q[15:8];
			end else if (acc_cmp_a) begin
				rdata_d = cmp_a_q;
				// only capture value goes through latch
				if (ctrl_q.wide && ctrl_q.capen) begin
					latch_d = cmp_b_q;
				end
			end else if (acc_cmp_b) begin
				rdata_d = (ctrl_q.wide && ctrl_q.capen) ? latch_q : cmp_b_q;
			end else begin
				// unmapped address reads as zero
				rdata_d = `TCR_READ_IDLE;
			end
		end

		// capture copies counter, sets flag
		// capture beats a processor write to the compare pair,
		// since losing a measured event is worse than losing a store
		if (edge_hit) begin
			cmp_a_d = cnt_q[7:0];
			if (ctrl_q.wide) begin
				cmp_b_d = cnt_q[15:8];
			end
			flags_d.cap = 1'b1;
		end

		// capture irq gated by mask bit
		irq_d = flags_d.cap & capture_irq_enable_i;
	end

	// register file registers
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl_q <= byte_to_ctrl(`TCR_CTRL_RST);
			// all counter and compare bytes zero
			cnt_q <= `TCR_WORD_RST;
			cmp_a_q <= `TCR_BYTE_RST;
			cmp_b_q <= `TCR_BYTE_RST;
			latch_q <= `TCR_BYTE_RST;
			block_q <= 1'b0;
			flags_q <= '0;
			rdata_q <= `TCR_READ_IDLE;
			irq_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			cnt_q <= cnt_d;
			cmp_a_q <= cmp_a_d;
			cmp_b_q <= cmp_b_d;
			latch_q <= latch_d;
			block_q <= block_d;
			flags_q <= flags_d;
			rdata_q <= rdata_d;
			irq_q <= irq_d;
		end
	end

	// outputs straight from flops
	assign rdata_o = rdata_q;
	assign flags_o = flags_q;
	assign capture_irq_o = irq_q;
	assign counter_o = cnt_q;

endmodule

/* hw/tcr_timer_end.sv */
`timescale 1ns/1ps
// holds no logic, the whole block lives in the timer module

/* test/tcr_timer_asserts.sv */
`timescale 1ns/1ps
`include "tcr_defs.svh"
// port checker for the timer block
module tcr_timer_asserts
	import tcr_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire tcr_bus_req_t bus_i,
	input wire logic [7:0] rdata_o,
	input wire logic timer_tick_i,
	input wire logic capture_irq_enable_i,
	input wire tcr_flags_t flag_clear_i,
	input wire tcr_flags_t flags_o,
	input wire logic capture_irq_o,
	input wire logic [15:0] counter_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	// address decodes to a real register
	logic mapped;
	assign mapped = bus_i.addr inside {`TCR_ADDR_CTRL, `TCR_ADDR_CNT_LO, `TCR_ADDR_CNT_HI, `TCR_ADDR_CMP_A,
		`TCR_ADDR_CMP_B};
	unmapped_read_a: assert property (bus_i.rd && !mapped |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	reserved_zero_a: assert property (bus_i.rd && bus_i.addr == `TCR_ADDR_CTRL |=> rdata_o[2:1] == 2'b00)
		else $error("reserved control bits not zero");
	read_hold_a: assert property (!bus_i.rd |=> $stable(rdata_o))
		else $error("read data moved without a read");
	low_write_a: assert property (bus_i.wr && bus_i.addr == `TCR_ADDR_CNT_LO |=>
		counter_o[7:0] == $past(bus_i.wdata))
		else $error("low byte write lost");
	count_hold_a: assert property (!timer_tick_i && !bus_i.wr |=> $stable(counter_o))
		else $error("counter moved without tick");
	count_step_a: assert property (timer_tick_i && !bus_i.wr |=>
		counter_o[7:0] == $past(counter_o[7:0]) + 8'h01 || counter_o[7:0] == 8'h00)
		else $error("counter step wrong");
	match_block_a: assert property (bus_i.wr && bus_i.addr == `TCR_ADDR_CNT_LO && !timer_tick_i
		##1 timer_tick_i |=> !$rose(flags_o.cmp_a) && !$rose(flags_o.cmp_b))
		else $error("match not blocked after write");
	flag_tick_a: assert property ($rose(flags_o.cmp_a) || $rose(flags_o.cmp_b) |-> $past(timer_tick_i))
		else $error("compare flag set without tick");
	flag_sticky_a: assert property ($fell(flags_o.cap) |-> $past(flag_clear_i.cap))
		else $error("capture flag dropped by itself");
	irq_mask_a: assert property (capture_irq_o == (flags_o.cap && $past(capture_irq_enable_i)))
		else $error("capture request mask wrong");
	// main scenarios seen at least once
	cap_seen_c: cover property ($rose(flags_o.cap));
	cmpa_seen_c: cover property ($rose(flags_o.cmp_a));
	cmpb_seen_c: cover property ($rose(flags_o.cmp_b));
endmodule
bind tcr_timer tcr_timer_asserts u_chk (.clk_i(clk_i), .resetn_i(resetn_i), .bus_i(bus_i), .rdata_o(rdata_o),
	.timer_tick_i(timer_tick_i), .capture_irq_enable_i(capture_irq_enable_i), .flag_clear_i(flag_clear_i),
	.flags_o(flags_o), .capture_irq_o(capture_irq_o), .counter_o(counter_o));

/* test/tcr_cpu_model.sv */
`timescale 1ns/1ps
// processor side of the 8-bit data bus
module tcr_cpu_model
	import tcr_pkg::*;
(
	input wire logic clk_i,
	input wire logic [7:0] rdata_i,
	output tcr_bus_req_t bus_o
);
	initial bus_o = '0;
	// one access, launched and released on falling edges
	task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w, output logic [7:0] q);
		@(negedge clk_i);
		bus_o = '{addr: a, wdata: d, wr: w, rd: !w};
		@(negedge clk_i);
		q = rdata_i;
		// released lines flip so stale values never look valid
		bus_o = '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		acc(a, d, 1'b1, q);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		acc(a, 8'h00, 1'b0, q);
	endtask
	task automatic wr16(input logic [7:0] lo, input logic [7:0] hi, input logic [15:0] v);
		wr(hi, v[15:8]);
		wr(lo, v[7:0]);
	endtask
	task automatic rd16(input logic [7:0] lo, input logic [7:0] hi, output logic [15:0] v);
		rd(lo, v[7:0]);
		rd(hi, v[15:8]);
	endtask
endmodule

/* test/tb.sv */
`timescale 1ns/1ps
`include "tcr_defs.svh"
module tb;
	import tcr_pkg::*;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	tcr_bus_req_t bus;
	logic [7:0] rdata;
	logic tick = 1'b0;
	logic pin = 1'b0;
	logic comp = 1'b0;
	logic irq_en = 1'b0;
	tcr_flags_t fclr = '0;
	tcr_flags_t flags;
	logic irq;
	logic [15:0] cnt;
	int n_mismatch = 0;
	int checks_done = 0;
	int nu;
	int nf;
	logic [7:0] q;
	logic [15:0] w;
	// reset image of every register plus one unmapped place
	logic [7:0] addrs [6] = '{`TCR_ADDR_CTRL, `TCR_ADDR_CNT_LO, `TCR_ADDR_CNT_HI, `TCR_ADDR_CMP_A,
		`TCR_ADDR_CMP_B, 8'h40};
	always #25 clk_i = ~clk_i;
	tcr_cpu_model u_cpu (.clk_i(clk_i), .rdata_i(rdata), .bus_o(bus));
	tcr_timer u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .bus_i(bus), .rdata_o(rdata), .timer_tick_i(tick),
		.capture_input_pin_i(pin), .comparator_out_i(comp), .capture_irq_enable_i(irq_en), .flag_clear_i(fclr),
		.flags_o(flags), .capture_irq_o(irq), .counter_o(cnt));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic pulse_tick();
		@(negedge clk_i) tick = 1'b1;
		@(negedge clk_i) tick = 1'b0;
	endtask
	// mode change may fire a capture, so settle then clear flags
	task automatic mode(input logic [7:0] c);
		u_cpu.wr(`TCR_ADDR_CTRL, c);
		repeat (8) @(negedge clk_i);
		fclr = '1;
		@(negedge clk_i) fclr = '0;
	endtask
	task automatic wait_cap(output int n);
		n = 0;
		while (flags.cap !== 1'b1) begin
			@(negedge clk_i);
			n++;
			if (n > 40) begin
				n_mismatch++;
				$display("[FAIL] %0t capture never seen", $time);
				stop_test();
			end
		end
	endtask
	initial begin
		repeat (2) @(posedge clk_i);
		@(negedge clk_i) resetn_i = 1'b1;
		foreach (addrs[i]) begin
			u_cpu.rd(addrs[i], q);
			chk(q, 16'h0000);
		end
		u_cpu.wr(`TCR_ADDR_CTRL, 8'hFF);
		u_cpu.rd(`TCR_ADDR_CTRL, q);
		chk(q, 16'h00F9);
		// wide mode: latch feeds compare B and counter high
		mode(8'h80);
		u_cpu.wr(`TCR_ADDR_CNT_HI, 8'hAB);
		u_cpu.wr(`TCR_ADDR_CMP_A, 8'h02);
		u_cpu.rd(`TCR_ADDR_CMP_B, q);
		chk(q, 16'h00AB);
		u_cpu.rd(`TCR_ADDR_CMP_A, q);
		chk(q, 16'h0002);
		u_cpu.wr(`TCR_ADDR_CNT_LO, 8'h02);
		chk(cnt, 16'hAB02);
		pulse_tick();
		chk(flags, 16'h0000);
		u_cpu.wr(`TCR_ADDR_CNT_LO, 8'h01);
		chk(cnt, 16'hAB01);
		pulse_tick();
		pulse_tick();
		chk(flags, 16'h0002);
		u_cpu.rd16(`TCR_ADDR_CNT_LO, `TCR_ADDR_CNT_HI, w);
		chk(w, 16'hAB03);
		u_cpu.wr16(`TCR_ADDR_CNT_LO, `TCR_ADDR_CNT_HI, 16'h01FF);
		chk(cnt, 16'h01FF);
		// narrow mode: both compares against the low byte
		mode(8'h00);
		u_cpu.wr(`TCR_ADDR_CMP_B, 8'h05);
		u_cpu.wr(`TCR_ADDR_CMP_A, 8'h09);
		u_cpu.wr(`TCR_ADDR_CNT_LO, 8'h04);
		pulse_tick();
		pulse_tick();
		chk(flags, 16'h0001);
		mode(8'h01);
		u_cpu.wr(`TCR_ADDR_CNT_LO, 8'h08);
		pulse_tick();
		pulse_tick();
		chk(flags, 16'h0002);
		chk(cnt[7:0], 16'h0000);
		// capture on rising pin, request masked
		u_cpu.wr(`TCR_ADDR_CNT_LO, 8'h77);
		mode(8'h50);
		@(negedge clk_i) pin = 1'b1;
		wait_cap(nu);
		chk(irq, 16'h0000);
		u_cpu.rd(`TCR_ADDR_CMP_A, q);
		chk(q, 16'h0077);
		// filtered falling edge: short glitch rejected, four cycles late
		irq_en = 1'b1;
		mode(8'h60);
		@(negedge clk_i) pin = 1'b0;
		repeat (2) @(negedge clk_i);
		pin = 1'b1;
		repeat (10) @(negedge clk_i);
		chk(flags, 16'h0000);
		pin = 1'b0;
		wait_cap(nf);
		chk(16'(nf), 16'(nu + 4));
		chk(irq, 16'h0001);
		// comparator as source, pin ignored
		mode(8'h58);
		@(negedge clk_i) pin = 1'b1;
		repeat (10) @(negedge clk_i);
		chk(flags, 16'h0000);
		comp = 1'b1;
		wait_cap(nu);
		chk(flags, 16'h0004);
		// wide capture read back through the latch
		pin = 1'b0;
		mode(8'h80);
		u_cpu.wr16(`TCR_ADDR_CNT_LO, `TCR_ADDR_CNT_HI, 16'h3C5A);
		mode(8'hD0);
		// stale latch value, so a direct high-byte read would show it
		u_cpu.wr(`TCR_ADDR_CNT_HI, 8'hE1);
		@(negedge clk_i) pin = 1'b1;
		wait_cap(nu);
		u_cpu.rd16(`TCR_ADDR_CMP_A, `TCR_ADDR_CMP_B, w);
		chk(w, 16'h3C5A);
		stop_test();
	end
endmodule
